/* File: tsm_pkg.sv */
// Constants, types and state encodings for the serial memory access test port
// Notes on behaviour
// - Capture-IR loads load-both-reloads code 0101
// - Counter snapshot path is capture only
// - Snapshot: read counter low, write counter high
// - Access only when counter top matches depth
// - Control bits 0-2 hold depth select, preset 000
// - Bits 3/5 choose clear or reload on reload
// - Bits 4/6 choose count up or down
// - Bit 7 selects asynchronous or synchronous output enable
// - Unused port leaves power-up configuration in force
// - Store: only input byte between serial pins
// - Store: idle cycle writes byte, advances counter
// - Store: output data pins held high impedance
// - Store path: input bit 7 nearest output
// - Fetch: idle cycle advances, reads, loads output byte
// - Fetch: only output byte, bit 0 nearest output
// - Fetch drives output pins when enable cell low
// - Quiet fetch: same, but outputs high impedance
// - Both reloads path: read low, write high
// - Control code 0010; capture and reset clear control
// - Control shift outputs zeros for first eight bits
// - Down counting clear mode reloads to FFFF
// - Mismatch blocks access, counter still advances
package tsm_pkg;
  localparam logic [3:0]  IR_BOTH        = 4'h5;
  localparam logic [3:0]  IR_CTRL        = 4'h2;
  localparam logic [3:0]  IR_RLD_F       = 4'h3;
  localparam logic [3:0]  IR_RLD_S       = 4'h4;
  localparam logic [3:0]  IR_SNAP        = 4'h8;
  localparam logic [3:0]  IR_STORE       = 4'h9;
  localparam logic [3:0]  IR_FETCH       = 4'ha;
  localparam logic [3:0]  IR_QUIET       = 4'hb;
  localparam logic [3:0]  IR_BYPASS      = 4'hf;
  localparam int          CTL_DEPTH_MSB  = 2;
  localparam int          CTL_WR_RELOAD  = 3;
  localparam int          CTL_WR_DOWN    = 4;
  localparam int          CTL_RD_RELOAD  = 5;
  localparam int          CTL_RD_DOWN    = 6;
  localparam int          CTL_OE_SYNC    = 7;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam int          CNT_TOP_MSB    = 15;
  localparam int          CNT_TOP_LSB    = 13;
  localparam logic [15:0] CNT_DOWN_CLEAR = 16'hffff;
  localparam int          LEN_WIDE       = 32;
  localparam int          LEN_RELOAD     = 16;
  localparam int          LEN_BYTE       = 8;
  localparam int          FIFO_DEPTH     = 8;
  typedef enum logic [15:0] {
    TS_RESET  = 16'h0001,
    TS_IDLE   = 16'h0002,
    TS_SEL_DR = 16'h0004,
    TS_CAP_DR = 16'h0008,
    TS_SH_DR  = 16'h0010,
    TS_EX1_DR = 16'h0020,
    TS_PAU_DR = 16'h0040,
    TS_EX2_DR = 16'h0080,
    TS_UPD_DR = 16'h0100,
    TS_SEL_IR = 16'h0200,
    TS_CAP_IR = 16'h0400,
    TS_SH_IR  = 16'h0800,
    TS_EX1_IR = 16'h1000,
    TS_PAU_IR = 16'h2000,
    TS_EX2_IR = 16'h4000,
    TS_UPD_IR = 16'h8000
  } tsm_tap_t;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
  } tsm_wreq_t;
endpackage

/* File: tsm_fifo.sv */
// Small first-in first-out buffer with valid and ready on both sides
module tsm_fifo #(
  parameter int W = 24,
  parameter int D = 8
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW:0]         wp;
    logic [AW:0]         rp;
  } tsm_fifo_st_t;
  tsm_fifo_st_t q;
  tsm_fifo_st_t d;
  always_comb
  begin
    d = q;
    in_ready = !((q.wp[AW] != q.rp[AW]) && (q.wp[AW-1:0] == q.rp[AW-1:0]));
    out_valid = (q.wp != q.rp);
    out_data = q.mem[q.rp[AW-1:0]];
    if (in_valid && in_ready)
    begin
      d.mem[q.wp[AW-1:0]] = in_data;
      d.wp = q.wp + 1'b1;
    end
    if (out_valid && out_ready)
      d.rp = q.rp + 1'b1;
  end
  always_ff @(posedge clock)
  begin
    if (rst)
      q <= '0;
    else
      q <= d;
  end
endmodule

/* File: tsm_top.sv */
// Test port data registers and quick serial store and fetch for the memory
module tsm_top (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        tck,
  input  wire logic        tms,
  input  wire logic        tdi,
  output logic             tdo,
  output logic             tdo_oe_n,
  input  wire logic [7:0]  input_data_pins,
  output logic [7:0]       output_data_pins,
  output logic             output_data_oe_n,
  input  wire logic        output_enable_n_cell,
  input  wire logic        store_advance_pin,
  input  wire logic        store_counter_reload_pin,
  input  wire logic        fetch_advance_pin,
  input  wire logic        fetch_counter_reload_pin,
  output logic [2:0]       depth_select_bits,
  output logic             output_enable_sync_select,
  output logic [15:0]      fetch_address_count_bits,
  output logic [15:0]      store_address_count_bits
);
  typedef struct packed {
    logic [2:0]        tck_s;
    logic [2:0]        tms_s;
    logic [2:0]        tdi_s;
    logic              tck_f;
    tsm_pkg::tsm_tap_t tap;
    logic [3:0]        ir_sh;
    logic [3:0]        ir;
    logic [31:0]       dr;
    logic              tdo;
    logic              tdo_oe_n;
    logic [7:0]        ctrl;
    logic [15:0]       fetch_reload_value;
    logic [15:0]       store_reload_value;
    logic [15:0]       rcnt;
    logic [15:0]       wcnt;
    logic [7:0]        sdata;
    logic [7:0]        dout;
    logic              qoe_n;
    logic              g_reg;
    logic              wpend;
    logic              rpend;
  } tsm_state_t;

  // Power-up configuration: count up from zero, clear on reload, depth 000
  localparam tsm_state_t ST_RST = '{
    tap:      tsm_pkg::TS_RESET,
    ir:       tsm_pkg::IR_BYPASS,
    ctrl:     tsm_pkg::CTRL_RESET,
    tdo_oe_n: 1'b1,
    qoe_n:    1'b1,
    default:  '0
  };

  tsm_state_t         q;
  tsm_state_t         d;
  logic               tck_rise;
  logic               tck_fall;
  logic               tms_v;
  logic               tdi_v;
  logic               run_edge;
  logic               wmatch;
  logic               rmatch;
  logic               g_eff;
  logic               push;
  logic               drain_valid;
  logic               drain_ready;
  logic               fifo_ready;
  logic [7:0]         mem_rd;
  logic [7:0]         pins_rev;
  tsm_pkg::tsm_wreq_t wreq;
  tsm_pkg::tsm_wreq_t drain;
  logic [7:0]         mem_q [0:65535];

  function automatic tsm_pkg::tsm_tap_t tap_next(input tsm_pkg::tsm_tap_t s, input logic m);
    case (s)
      tsm_pkg::TS_RESET:  return m ? tsm_pkg::TS_RESET : tsm_pkg::TS_IDLE;
      tsm_pkg::TS_IDLE:   return m ? tsm_pkg::TS_SEL_DR : tsm_pkg::TS_IDLE;
      tsm_pkg::TS_SEL_DR: return m ? tsm_pkg::TS_SEL_IR : tsm_pkg::TS_CAP_DR;
      tsm_pkg::TS_CAP_DR: return m ? tsm_pkg::TS_EX1_DR : tsm_pkg::TS_SH_DR;
      tsm_pkg::TS_SH_DR:  return m ? tsm_pkg::TS_EX1_DR : tsm_pkg::TS_SH_DR;
      tsm_pkg::TS_EX1_DR: return m ? tsm_pkg::TS_UPD_DR : tsm_pkg::TS_PAU_DR;
      tsm_pkg::TS_PAU_DR: return m ? tsm_pkg::TS_EX2_DR : tsm_pkg::TS_PAU_DR;
      tsm_pkg::TS_EX2_DR: return m ? tsm_pkg::TS_UPD_DR : tsm_pkg::TS_SH_DR;
      tsm_pkg::TS_UPD_DR: return m ? tsm_pkg::TS_SEL_DR : tsm_pkg::TS_IDLE;
      tsm_pkg::TS_SEL_IR: return m ? tsm_pkg::TS_RESET : tsm_pkg::TS_CAP_IR;
      tsm_pkg::TS_CAP_IR: return m ? tsm_pkg::TS_EX1_IR : tsm_pkg::TS_SH_IR;
      tsm_pkg::TS_SH_IR:  return m ? tsm_pkg::TS_EX1_IR : tsm_pkg::TS_SH_IR;
      tsm_pkg::TS_EX1_IR: return m ? tsm_pkg::TS_UPD_IR : tsm_pkg::TS_PAU_IR;
      tsm_pkg::TS_PAU_IR: return m ? tsm_pkg::TS_EX2_IR : tsm_pkg::TS_PAU_IR;
      tsm_pkg::TS_EX2_IR: return m ? tsm_pkg::TS_UPD_IR : tsm_pkg::TS_SH_IR;
      tsm_pkg::TS_UPD_IR: return m ? tsm_pkg::TS_SEL_DR : tsm_pkg::TS_IDLE;
      default:            return tsm_pkg::TS_RESET;
    endcase
  endfunction

  // Serial input enters at the top of the selected path, bit 0 leaves first
  function automatic logic [31:0] shift_dr(input logic [31:0] v, input logic b,
                                           input logic [3:0] ir);
    logic [31:0] r;
    r = {1'b0, v[31:1]};
    case (ir)
      tsm_pkg::IR_SNAP, tsm_pkg::IR_BOTH: r[tsm_pkg::LEN_WIDE-1] = b;
      tsm_pkg::IR_RLD_F, tsm_pkg::IR_RLD_S: r[tsm_pkg::LEN_RELOAD-1] = b;
      tsm_pkg::IR_CTRL, tsm_pkg::IR_STORE,
      tsm_pkg::IR_FETCH, tsm_pkg::IR_QUIET: r[tsm_pkg::LEN_BYTE-1] = b;
      default: r[0] = b;
    endcase
    return r;
  endfunction

  function automatic logic [15:0] reload_val(input logic sel, input logic down,
                                             input logic [15:0] rl);
    if (sel)
      return rl;
    return down ? tsm_pkg::CNT_DOWN_CLEAR : 16'h0000;
  endfunction

  function automatic logic [15:0] step(input logic [15:0] c, input logic down);
    return down ? c - 16'h0001 : c + 16'h0001;
  endfunction

  assign mem_rd = mem_q[q.rcnt];
  assign wreq = '{addr: q.wcnt, data: q.sdata};
  // The array has one port, so a pending fetch read holds off the drain
  assign drain_ready = !q.rpend;

  // Store path holds the pins reversed so that data bit 7 leaves first
  for (genvar i = 0; i < tsm_pkg::LEN_BYTE; i++)
  begin : g_pin_rev
    assign pins_rev[i] = input_data_pins[tsm_pkg::LEN_BYTE - 1 - i];
  end

  tsm_fifo #(
    .W ($bits(tsm_pkg::tsm_wreq_t)),
    .D (tsm_pkg::FIFO_DEPTH)
  ) tsm_fifo_inst (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   (wreq),
    .out_valid (drain_valid),
    .out_ready (drain_ready),
    .out_data  (drain)
  );

  always_ff @(posedge clock)
  begin
    if (drain_valid && drain_ready)
      mem_q[drain.addr] <= drain.data;
  end

  always_comb
  begin
    d = q;
    push = 1'b0;
    // Only the second and third stages are compared; the first just settles
    d.tck_s = {q.tck_s[1:0], tck};
    d.tms_s = {q.tms_s[1:0], tms};
    d.tdi_s = {q.tdi_s[1:0], tdi};
    if (q.tck_s[1] == q.tck_s[2])
      d.tck_f = q.tck_s[2];
    tck_rise = q.tck_s[1] & q.tck_s[2] & ~q.tck_f;
    tck_fall = ~q.tck_s[1] & ~q.tck_s[2] & q.tck_f;
    tms_v = q.tms_s[2];
    tdi_v = q.tdi_s[2];
    run_edge = tck_rise && (q.tap == tsm_pkg::TS_IDLE);
    wmatch = q.wcnt[tsm_pkg::CNT_TOP_MSB:tsm_pkg::CNT_TOP_LSB]
             == q.ctrl[tsm_pkg::CTL_DEPTH_MSB:0];
    rmatch = q.rcnt[tsm_pkg::CNT_TOP_MSB:tsm_pkg::CNT_TOP_LSB]
             == q.ctrl[tsm_pkg::CTL_DEPTH_MSB:0];

    // A mismatched write is dropped but still moves the counter on
    if (q.wpend)
    begin
      if (!wmatch)
      begin
        d.wcnt = step(q.wcnt, q.ctrl[tsm_pkg::CTL_WR_DOWN]);
        d.wpend = 1'b0;
      end
      else if (fifo_ready)
      begin
        push = 1'b1;
        d.wcnt = step(q.wcnt, q.ctrl[tsm_pkg::CTL_WR_DOWN]);
        d.wpend = 1'b0;
      end
    end
    if (q.rpend)
    begin
      d.rpend = 1'b0;
      if (rmatch)
        d.dout = mem_rd;
    end

    if (tck_rise)
    begin
      d.tap = tap_next(q.tap, tms_v);
      case (q.tap)
        tsm_pkg::TS_RESET:  d.ir = tsm_pkg::IR_BYPASS;
        tsm_pkg::TS_CAP_IR: d.ir_sh = tsm_pkg::IR_BOTH;
        tsm_pkg::TS_SH_IR:  d.ir_sh = {tdi_v, q.ir_sh[3:1]};
        tsm_pkg::TS_UPD_IR: d.ir = q.ir_sh;
        tsm_pkg::TS_CAP_DR:
        begin
          case (q.ir)
            tsm_pkg::IR_SNAP:  d.dr = {q.wcnt, q.rcnt};
            tsm_pkg::IR_STORE: d.dr = {24'h000000, pins_rev};
            tsm_pkg::IR_FETCH,
            tsm_pkg::IR_QUIET: d.dr = {24'h000000, q.dout};
            tsm_pkg::IR_RLD_F: d.dr = {16'h0000, q.fetch_reload_value};
            tsm_pkg::IR_RLD_S: d.dr = {16'h0000, q.store_reload_value};
            tsm_pkg::IR_BOTH:  d.dr = {q.store_reload_value, q.fetch_reload_value};
            tsm_pkg::IR_CTRL:
            begin
              d.ctrl = tsm_pkg::CTRL_RESET;
              d.dr = 32'h00000000;
            end
            default:           d.dr = 32'h00000000;
          endcase
        end
        tsm_pkg::TS_SH_DR:  d.dr = shift_dr(q.dr, tdi_v, q.ir);
        tsm_pkg::TS_UPD_DR:
        begin
          // Counter snapshot has no update: shifting in never touches counters
          case (q.ir)
            tsm_pkg::IR_CTRL:  d.ctrl = q.dr[7:0];
            tsm_pkg::IR_RLD_F: d.fetch_reload_value = q.dr[15:0];
            tsm_pkg::IR_RLD_S: d.store_reload_value = q.dr[15:0];
            tsm_pkg::IR_BOTH:
            begin
              d.fetch_reload_value = q.dr[15:0];
              d.store_reload_value = q.dr[31:16];
            end
            tsm_pkg::IR_STORE: d.sdata = {<<{q.dr[7:0]}};
            default:           d.ctrl = q.ctrl;
          endcase
        end
        default:            d.ir = q.ir;
      endcase
    end

    // Each idle cycle is one action; the reload cell takes priority
    if (run_edge && (q.ir == tsm_pkg::IR_STORE))
    begin
      if (!store_counter_reload_pin)
        d.wcnt = reload_val(q.ctrl[tsm_pkg::CTL_WR_RELOAD],
                            q.ctrl[tsm_pkg::CTL_WR_DOWN], q.store_reload_value);
      else if (store_advance_pin)
        d.wpend = 1'b1;
    end
    if (run_edge && ((q.ir == tsm_pkg::IR_FETCH) || (q.ir == tsm_pkg::IR_QUIET)))
    begin
      if (!fetch_counter_reload_pin)
        d.rcnt = reload_val(q.ctrl[tsm_pkg::CTL_RD_RELOAD],
                            q.ctrl[tsm_pkg::CTL_RD_DOWN], q.fetch_reload_value);
      else if (fetch_advance_pin)
      begin
        d.rcnt = step(q.rcnt, q.ctrl[tsm_pkg::CTL_RD_DOWN]);
        d.rpend = 1'b1;
      end
    end

    // Serial output changes on the falling edge, as the controller expects
    if (tck_fall)
    begin
      d.tdo = (q.tap == tsm_pkg::TS_SH_IR) ? q.ir_sh[0] : q.dr[0];
      d.tdo_oe_n = !((q.tap == tsm_pkg::TS_SH_IR) || (q.tap == tsm_pkg::TS_SH_DR));
    end

    // Synchronous mode costs one clock of latency on the enable cell
    d.g_reg = output_enable_n_cell;
    g_eff = q.ctrl[tsm_pkg::CTL_OE_SYNC] ? q.g_reg : output_enable_n_cell;
    d.qoe_n = (q.ir == tsm_pkg::IR_STORE)
              || (q.ir == tsm_pkg::IR_QUIET)
              || !rmatch
              || g_eff;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      q <= ST_RST;
    else
      q <= d;
  end

  assign tdo = q.tdo;
  assign tdo_oe_n = q.tdo_oe_n;
  assign output_data_pins = q.dout;
  assign output_data_oe_n = q.qoe_n;
  assign depth_select_bits = q.ctrl[tsm_pkg::CTL_DEPTH_MSB:0];
  assign output_enable_sync_select = q.ctrl[tsm_pkg::CTL_OE_SYNC];
  assign fetch_address_count_bits = q.rcnt;
  assign store_address_count_bits = q.wcnt;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_fetch_ev;
    run_edge && (q.ir == tsm_pkg::IR_FETCH) && fetch_counter_reload_pin && fetch_advance_pin;
  endsequence
  sequence s_ctrl_cap;
    tck_rise && (q.tap == tsm_pkg::TS_CAP_DR) && (q.ir == tsm_pkg::IR_CTRL);
  endsequence

  property p_cap_ir;
    (tck_rise && (q.tap == tsm_pkg::TS_CAP_IR)) |=> (q.ir_sh == 4'h5);
  endproperty
  a_cap_ir: assert property (p_cap_ir) else $error("capture-ir preset wrong");

  property p_snap_cap;
    (tck_rise && (q.tap == tsm_pkg::TS_CAP_DR) && (q.ir == tsm_pkg::IR_SNAP))
      |=> (q.dr == {$past(q.wcnt), $past(q.rcnt)});
  endproperty
  a_snap_cap: assert property (p_snap_cap) else $error("snapshot capture wrong");

  property p_snap_keep;
    ((q.ir == tsm_pkg::IR_SNAP) && (q.tap != tsm_pkg::TS_IDLE) && !q.wpend)
      |=> ($stable(q.rcnt) && $stable(q.wcnt));
  endproperty
  a_snap_keep: assert property (p_snap_keep) else $error("snapshot moved counter");

  property p_ctrl_cap;
    s_ctrl_cap |=> ((q.ctrl == 8'h00) && (q.dr[7:0] == 8'h00));
  endproperty
  a_ctrl_cap: assert property (p_ctrl_cap) else $error("control capture not zero");

  property p_store_hiz;
    (q.ir == tsm_pkg::IR_STORE) |=> output_data_oe_n;
  endproperty
  a_store_hiz: assert property (p_store_hiz) else $error("store drives outputs");

  property p_quiet_hiz;
    // The enable lags the instruction by one clock, so look once quiet has stood a clock
    ((q.ir == tsm_pkg::IR_QUIET) && $past(q.ir == tsm_pkg::IR_QUIET))
      |-> output_data_oe_n [*2];
  endproperty
  a_quiet_hiz: assert property (p_quiet_hiz) else $error("quiet fetch drives");

  property p_wr_block;
    (q.wpend && !wmatch) |-> !push ##1 (q.wcnt != $past(q.wcnt));
  endproperty
  a_wr_block: assert property (p_wr_block) else $error("mismatch write wrong");

  property p_match;
    push |-> (q.wcnt[15:13] == q.ctrl[2:0]);
  endproperty
  a_match: assert property (p_match) else $error("write without depth match");

  property p_fetch;
    s_fetch_ev ##1 (q.rpend && rmatch) |=> (q.dout == $past(mem_rd));
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch data not loaded");

  property p_reload_down;
    (run_edge && (q.ir == tsm_pkg::IR_FETCH) && !fetch_counter_reload_pin
      && !q.ctrl[5] && q.ctrl[6]) |=> (q.rcnt == 16'hffff);
  endproperty
  a_reload_down: assert property (p_reload_down) else $error("down clear not ffff");
endmodule

/* File: tsm_ctl_model.sv */
// Test controller model: drives the test clock, mode select and serial data
module tsm_ctl_model (
  input  wire logic clock,
  input  wire logic tdo,
  output logic      tck,
  output logic      tms,
  output logic      tdi
);
  timeunit 1ns;
  timeprecision 1ps;

  // Test clock stands low between frames; data idles high like the pulled-up pin
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  // One test clock period of 8 system clocks; serial out taken late in the high phase
  task automatic tick(input logic m, input logic d, output logic b);
    tms = m;
    tdi = d;
    repeat (4) @(negedge clock);
    tck = 1'b1;
    repeat (4) @(negedge clock);
    b = tdo;
    tck = 1'b0;
  endtask

  // Idle to idle; the first rise is taken in Run-Test/Idle and so performs one idle action
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic b;
    dout = '0;
    tick(1'b1, 1'b1, b);
    if (ir)
      tick(1'b1, 1'b1, b);
    // Select to Capture, then Capture to Shift, or straight to Exit1 with nothing to shift
    tick(1'b0, 1'b1, b);
    tick(n == 0, 1'b1, b);
    for (int i = 0; i < n; i++)
    begin
      tick(i == n - 1, din[i], b);
      dout[i] = b;
    end
    tick(1'b1, 1'b1, b);
    tick(1'b0, 1'b1, b);
  endtask
endmodule

/* File: tsm_top_bench.sv */
// Self-checking bench for the serial memory access test port
module tsm_top_bench;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [7:0]  ctl;
    logic [15:0] fetch_reload_value;
    logic [15:0] store_reload_value;
  } tsm_row_t;

  logic        clock;
  logic        rst;
  logic        tck;
  logic        tms;
  logic        tdi;
  logic        tdo;
  logic        tdo_oe_n;
  logic [7:0]  input_data_pins;
  logic [7:0]  output_data_pins;
  logic        output_data_oe_n;
  logic        output_enable_n_cell;
  logic        store_advance_pin;
  logic        store_counter_reload_pin;
  logic        fetch_advance_pin;
  logic        fetch_counter_reload_pin;
  logic [2:0]  depth_select_bits;
  logic        output_enable_sync_select;
  logic [15:0] fetch_address_count_bits;
  logic [15:0] store_address_count_bits;
  int          n_mismatch;
  int          checked;
  int          cycles = 0;
  logic [31:0] d;
  logic [31:0] last;
  logic [15:0] es;
  logic [15:0] ef;
  logic [7:0]  s [4];
  tsm_row_t    rows [5];

  tsm_top tsm_top_inst (.clock(clock), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe_n(tdo_oe_n), .input_data_pins(input_data_pins),
    .output_data_pins(output_data_pins), .output_data_oe_n(output_data_oe_n),
    .output_enable_n_cell(output_enable_n_cell), .store_advance_pin(store_advance_pin),
    .store_counter_reload_pin(store_counter_reload_pin),
    .fetch_advance_pin(fetch_advance_pin),
    .fetch_counter_reload_pin(fetch_counter_reload_pin),
    .depth_select_bits(depth_select_bits),
    .output_enable_sync_select(output_enable_sync_select),
    .fetch_address_count_bits(fetch_address_count_bits),
    .store_address_count_bits(store_address_count_bits));

  tsm_ctl_model tsm_ctl_model_inst (.clock(clock), .tdo(tdo), .tck(tck), .tms(tms),
    .tdi(tdi));

  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // A hang is cut short well beyond the expected run of about 8800 cycles
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end

  function automatic logic [7:0] rev8(input logic [7:0] v);
    for (int i = 0; i < 8; i++)
      rev8[i] = v[7 - i];
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic ir(input logic [3:0] code);
    tsm_ctl_model_inst.scan(1'b1, 4, {28'h0, code}, d);
  endtask

  task automatic dr(input int n, input logic [31:0] din);
    tsm_ctl_model_inst.scan(1'b0, n, din, d);
  endtask

  task automatic settle;
    repeat (6) @(negedge clock);
  endtask

  task automatic ctl_load(input logic [7:0] v);
    ir(tsm_pkg::IR_CTRL);
    dr(8, {24'h0, v});
    check(d, 32'h0);
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    n_mismatch = 0;
    checked = 0;
    last = '0;
    rst = 1'b1;
    input_data_pins = 8'h00;
    output_enable_n_cell = 1'b1;
    store_advance_pin = 1'b0;
    store_counter_reload_pin = 1'b1;
    fetch_advance_pin = 1'b0;
    fetch_counter_reload_pin = 1'b1;
    s = '{8'h5a, 8'hc3, 8'h01, 8'hfe};
    // Every row leaves the stepped read counter outside its depth block: no unwritten reads
    rows = '{'{8'h01, 16'h1234, 16'habcd}, '{8'h28, 16'h2345, 16'h3456},
             '{8'h50, 16'h4567, 16'h5678}, '{8'h78, 16'h6789, 16'h789a},
             '{8'h87, 16'h0f0f, 16'hf0f0}};
    repeat (3) @(negedge clock);
    rst = 1'b0;
    settle();
    check({depth_select_bits, output_enable_sync_select}, 4'h0);
    check({fetch_address_count_bits, store_address_count_bits}, 32'h0);
    check({output_data_oe_n, tdo_oe_n, output_data_pins}, 10'h300);
    tsm_ctl_model_inst.tick(1'b0, 1'b1, d[0]);
    ir(tsm_pkg::IR_BYPASS);
    check(d, 32'h5);
    $display("test reset done");
    foreach (rows[r])
    begin
      tsm_ctl_model_inst.scan(1'b1, 0, 32'h0, d);
      dr(32, {rows[r].store_reload_value, rows[r].fetch_reload_value});
      check(d, last);
      last = {rows[r].store_reload_value, rows[r].fetch_reload_value};
      ctl_load(rows[r].ctl);
      settle();
      check(depth_select_bits, rows[r].ctl[2:0]);
      check(output_enable_sync_select, rows[r].ctl[7]);
      store_counter_reload_pin = 1'b0;
      ir(tsm_pkg::IR_STORE);
      ir(tsm_pkg::IR_FETCH);
      store_counter_reload_pin = 1'b1;
      fetch_counter_reload_pin = 1'b0;
      ir(tsm_pkg::IR_FETCH);
      fetch_counter_reload_pin = 1'b1;
      fetch_advance_pin = 1'b1;
      ir(tsm_pkg::IR_SNAP);
      fetch_advance_pin = 1'b0;
      es = rows[r].ctl[3] ? rows[r].store_reload_value : {16{rows[r].ctl[4]}};
      ef = rows[r].ctl[5] ? rows[r].fetch_reload_value : {16{rows[r].ctl[6]}};
      ef = rows[r].ctl[6] ? ef - 16'h1 : ef + 16'h1;
      dr(32, 32'hffffffff);
      check(d, {es, ef});
      settle();
      check({store_address_count_bits, fetch_address_count_bits}, {es, ef});
      $display("test row %0d done", r);
    end
    // Store four bytes from address 0, then fetch them back from a read counter at ffff
    tsm_ctl_model_inst.scan(1'b1, 0, 32'h0, d);
    dr(32, 32'h0000ffff);
    ctl_load(8'h20);
    store_counter_reload_pin = 1'b0;
    ir(tsm_pkg::IR_STORE);
    settle();
    check(output_data_oe_n, 1'b1);
    input_data_pins = 8'h1d;
    dr(8, {24'h0, rev8(s[0])});
    check(d, {24'h0, rev8(8'h1d)});
    store_counter_reload_pin = 1'b1;
    store_advance_pin = 1'b1;
    for (int k = 1; k < 4; k++)
      dr(8, {24'h0, rev8(s[k])});
    ir(tsm_pkg::IR_FETCH);
    store_advance_pin = 1'b0;
    settle();
    check(store_address_count_bits, 16'h0004);
    output_enable_n_cell = 1'b0;
    fetch_counter_reload_pin = 1'b0;
    ir(tsm_pkg::IR_FETCH);
    fetch_counter_reload_pin = 1'b1;
    fetch_advance_pin = 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      dr(8, 32'h0);
      check(d, {24'h0, s[k]});
      settle();
      check({output_data_oe_n, output_data_pins}, {1'b0, s[k]});
    end
    fetch_advance_pin = 1'b0;
    fetch_counter_reload_pin = 1'b0;
    ir(tsm_pkg::IR_QUIET);
    fetch_counter_reload_pin = 1'b1;
    fetch_advance_pin = 1'b1;
    dr(8, 32'h0);
    check(d, {24'h0, s[0]});
    settle();
    check(output_data_oe_n, 1'b1);
    fetch_advance_pin = 1'b0;
    $display("test store and fetch done");
    // Depth select 1 against counters in the 000 block: access refused, counters step
    ctl_load(8'h21);
    store_counter_reload_pin = 1'b0;
    ir(tsm_pkg::IR_STORE);
    dr(8, {24'h0, rev8(8'h77)});
    store_counter_reload_pin = 1'b1;
    store_advance_pin = 1'b1;
    ir(tsm_pkg::IR_FETCH);
    store_advance_pin = 1'b0;
    fetch_counter_reload_pin = 1'b0;
    dr(8, 32'h0);
    fetch_counter_reload_pin = 1'b1;
    fetch_advance_pin = 1'b1;
    dr(8, 32'h0);
    fetch_advance_pin = 1'b0;
    settle();
    check(output_data_oe_n, 1'b1);
    check({store_address_count_bits, fetch_address_count_bits}, 32'h00010000);
    ctl_load(8'h20);
    fetch_counter_reload_pin = 1'b0;
    ir(tsm_pkg::IR_FETCH);
    dr(8, 32'h0);
    fetch_counter_reload_pin = 1'b1;
    fetch_advance_pin = 1'b1;
    dr(8, 32'h0);
    fetch_advance_pin = 1'b0;
    check(d, {24'h0, s[0]});
    $display("test depth mismatch done");
    end_of_test();
  end
endmodule
